// file: verilog/pdc_pkg.sv
// Shared constants for the second-stage loop divider control block
package pdc_pkg;
  // Wishbone geometry
  localparam int unsigned ADR_W  = 12;
  localparam int unsigned DAT_W  = 32;
  localparam int unsigned SEL_W  = 4;
  localparam int unsigned IDX_LO = 2;
  localparam int unsigned IDX_W  = ADR_W - IDX_LO;
  localparam int unsigned REG_W  = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LOOP_FILTER_LOW    = 10'h205;
  localparam logic [IDX_W-1:0] IDX_ZERO_BYPASS        = 10'h206;
  localparam logic [IDX_W-1:0] IDX_REF_PREDIV         = 10'h207;
  localparam logic [IDX_W-1:0] IDX_FB_RATIO           = 10'h208;
  localparam logic [IDX_W-1:0] IDX_FB_PHASE_PD        = 10'h209;
  localparam logic [IDX_W-1:0] IDX_STATUS             = 10'h20a;

  // Field layout
  localparam int unsigned REF_DIV_W   = 5;
  localparam int unsigned FB_DIV_W    = 8;
  localparam int unsigned FB_PHASE_W  = 6;
  localparam int unsigned FB_PD_BIT   = 6;
  localparam int unsigned BYPASS_BIT  = 0;
  localparam int unsigned LF_WORD_W   = REG_W + 1;
  // Feedback counter runs in half periods of its input clock
  localparam int unsigned FB_CNT_W    = FB_DIV_W + 1;

  // Reset values
  localparam logic [REG_W-1:0]     RST_LOOP_FILTER_LOW = 8'h00;
  localparam logic                 RST_ZERO_BYPASS     = 1'b0;
  localparam logic [REF_DIV_W-1:0] RST_REF_PREDIV      = 5'h01;
  localparam logic [FB_DIV_W-1:0]  RST_FB_RATIO        = 8'h00;
  localparam logic [FB_PHASE_W-1:0] RST_FB_PHASE       = 6'h00;
  localparam logic                 RST_FB_PD           = 1'b0;

  // Largest ratio code that still divides by one
  localparam logic [REF_DIV_W-1:0] REF_MIN_CODE = 5'h01;
  localparam logic [DAT_W-1:0]     DAT_ZERO     = 32'h0000_0000;
endpackage

// file: verilog/pdc_div_if.sv
// Control and result bundle between the block and one divider counter
`timescale 1ns/1ps
interface pdc_div_if #(
  parameter int unsigned W = 8
);
  logic         step;
  logic         hold;
  logic         load;
  logic [W-1:0] top;
  logic [W-1:0] load_val;
  logic [W-1:0] cnt;
  logic         wrap;

  modport ctl (output step, hold, load, top, load_val, input cnt, wrap);
  modport div (input step, hold, load, top, load_val, output cnt, wrap);
endinterface

// file: verilog/pdc_div_counter.sv
// Programmable modulo counter with phase load and power-down hold
`timescale 1ns/1ps
module pdc_div_counter #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // Divider bundle
  pdc_div_if.div    dv
);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || dv.hold) begin
      dv.cnt <= '0;
    end else if (dv.load) begin
      dv.cnt <= dv.load_val;
    end else if (dv.step) begin
      // Wrap on >= so a top lowered mid-count cannot run away
      if (dv.cnt >= dv.top) begin
        dv.cnt <= '0;
      end else begin
        dv.cnt <= dv.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || dv.hold || dv.load) begin
      dv.wrap <= 1'b0;
    end else begin
      dv.wrap <= dv.step && (dv.cnt >= dv.top);
    end
  end

  a_cnt_wraps_top: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    dv.step && !dv.hold && !dv.load && dv.cnt >= dv.top |=> dv.wrap && dv.cnt == '0)
    else $error("counter did not wrap at top");
  a_hold_clears_cnt: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    dv.hold [*2] |-> dv.cnt == '0 && !dv.wrap)
    else $error("held counter not cleared");
endmodule

// file: verilog/pdc_ctrl.sv
// Wishbone register file and divider control for the second-stage loop
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module pdc_ctrl (
  // Clock and reset
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst,
  // Wishbone slave
  input  wire logic                          i_wb_cyc,
  input  wire logic                          i_wb_stb,
  input  wire logic                          i_wb_we,
  input  wire logic [pdc_pkg::ADR_W-1:0]     i_wb_adr,
  input  wire logic [pdc_pkg::DAT_W-1:0]     i_wb_dat,
  input  wire logic [pdc_pkg::SEL_W-1:0]     i_wb_sel,
  output logic                               o_wb_ack,
  output logic [pdc_pkg::DAT_W-1:0]          o_wb_dat,
  // Divider inputs
  input  wire logic                          i_ref_edge,
  input  wire logic                          i_vco_edge,
  input  wire logic                          i_sync,
  // Divider outputs
  output logic                               o_ref_div_pulse,
  output logic                               o_fb_div_pulse,
  output logic                               o_fb_powered_down,
  // Loop filter
  output logic                               o_loop_zero_bypass,
  output logic [pdc_pkg::LF_WORD_W-1:0]      o_loop_filter_word
);
  import pdc_pkg::*;

  logic [REG_W-1:0]      loop_filter_low;
  logic                  zero_bypass;
  logic [REF_DIV_W-1:0]  ref_prediv;
  logic [FB_DIV_W-1:0]   fb_ratio;
  logic [FB_PHASE_W-1:0] fb_phase;
  logic                  fb_pd;
  logic                  wb_access;
  logic                  wb_write;
  logic                  wb_read;
  logic [IDX_W-1:0]      wb_idx;
  logic [DAT_W-1:0]      next_rd_dat;

  pdc_div_if #(.W(REF_DIV_W)) ref_if ();
  pdc_div_if #(.W(FB_CNT_W))  fb_if ();

  function automatic logic reg_hit(input logic [IDX_W-1:0] idx,
                                   input logic [IDX_W-1:0] target);
    reg_hit = (idx == target);
  endfunction

  // Wishbone handshake: one wait state, ack drops the cycle after
  assign wb_access = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wb_write  = wb_access && i_wb_we && i_wb_sel[0];
  assign wb_read   = wb_access && !i_wb_we;
  assign wb_idx    = i_wb_adr[ADR_W-1:IDX_LO];

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= wb_access;
    end
  end

  // Write side; only the low byte lane carries register bits
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      loop_filter_low <= RST_LOOP_FILTER_LOW;
    end else if (wb_write && reg_hit(wb_idx, IDX_LOOP_FILTER_LOW)) begin
      loop_filter_low <= i_wb_dat[REG_W-1:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      zero_bypass <= RST_ZERO_BYPASS;
    end else if (wb_write && reg_hit(wb_idx, IDX_ZERO_BYPASS)) begin
      zero_bypass <= i_wb_dat[BYPASS_BIT];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ref_prediv <= RST_REF_PREDIV;
    end else if (wb_write && reg_hit(wb_idx, IDX_REF_PREDIV)) begin
      ref_prediv <= i_wb_dat[REF_DIV_W-1:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fb_ratio <= RST_FB_RATIO;
    end else if (wb_write && reg_hit(wb_idx, IDX_FB_RATIO)) begin
      fb_ratio <= i_wb_dat[FB_DIV_W-1:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fb_phase <= RST_FB_PHASE;
      fb_pd    <= RST_FB_PD;
    end else if (wb_write && reg_hit(wb_idx, IDX_FB_PHASE_PD)) begin
      fb_phase <= i_wb_dat[FB_PHASE_W-1:0];
      fb_pd    <= i_wb_dat[FB_PD_BIT];
    end
  end

  // Read side; reserved bits and unmapped addresses read zero
  always_comb begin
    next_rd_dat = DAT_ZERO;
    case (wb_idx)
      IDX_LOOP_FILTER_LOW: next_rd_dat[REG_W-1:0] = loop_filter_low;
      IDX_ZERO_BYPASS:     next_rd_dat[BYPASS_BIT] = zero_bypass;
      IDX_REF_PREDIV:      next_rd_dat[REF_DIV_W-1:0] = ref_prediv;
      IDX_FB_RATIO:        next_rd_dat[FB_DIV_W-1:0] = fb_ratio;
      IDX_FB_PHASE_PD: begin
        next_rd_dat[FB_PHASE_W-1:0] = fb_phase;
        next_rd_dat[FB_PD_BIT]      = fb_pd;
      end
      IDX_STATUS: begin
        next_rd_dat[0] = !fb_pd;
        next_rd_dat[1] = (ref_prediv <= REF_MIN_CODE);
      end
      default: next_rd_dat = DAT_ZERO;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_wb_dat <= DAT_ZERO;
    end else if (wb_read) begin
      o_wb_dat <= next_rd_dat;
    end
  end

  // Reference pre-divider: codes 0 and 1 both give a top of zero
  assign ref_if.step     = i_ref_edge;
  assign ref_if.hold     = 1'b0;
  assign ref_if.load     = 1'b0;
  assign ref_if.load_val = '0;
  assign ref_if.top      = (ref_prediv <= REF_MIN_CODE) ? '0
                           : ref_prediv - REF_DIV_W'(1);

  // Feedback divider counts both edges, so a period is two steps
  assign fb_if.step     = i_vco_edge;
  assign fb_if.hold     = fb_pd;
  assign fb_if.load     = i_sync;
  assign fb_if.load_val = FB_CNT_W'(fb_phase);
  assign fb_if.top      = {fb_ratio, 1'b1};

  pdc_div_counter #(.W(REF_DIV_W)) u_ref_div (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .dv        (ref_if.div)
  );

  pdc_div_counter #(.W(FB_CNT_W)) u_fb_div (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .dv        (fb_if.div)
  );

  assign o_ref_div_pulse   = ref_if.wrap;
  assign o_fb_div_pulse    = fb_if.wrap;
  assign o_fb_powered_down = fb_pd;
  // Hazard: bypass without an external resistor leaves the loop with no zero
  assign o_loop_zero_bypass = zero_bypass;
  assign o_loop_filter_word = {zero_bypass, loop_filter_low};

  a_ref_div_one: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ref_edge && ref_prediv <= REF_MIN_CODE |=> o_ref_div_pulse)
    else $error("pre-divider code 0 or 1 did not divide by one");
  a_ref_div_count: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ref_edge && ref_prediv > REF_MIN_CODE && ref_if.cnt == ref_prediv - REF_DIV_W'(1)
    |=> o_ref_div_pulse)
    else $error("pre-divider wrap at wrong count");
  a_fb_wrap_point: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_vco_edge && !fb_pd && !i_sync && fb_if.cnt == {fb_ratio, 1'b1}
    |=> o_fb_div_pulse ##1 !o_fb_div_pulse || i_vco_edge)
    else $error("feedback divider wrap at wrong count");
  a_sync_phase_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_sync && !fb_pd |=> fb_if.cnt == FB_CNT_W'($past(fb_phase)) && !o_fb_div_pulse)
    else $error("sync did not load the phase");
  a_pd_stops_fb: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    fb_pd |=> !o_fb_div_pulse && fb_if.cnt == '0)
    else $error("powered-down feedback divider still runs");
  a_bypass_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_write && reg_hit(wb_idx, IDX_ZERO_BYPASS)
    |=> o_loop_zero_bypass == $past(i_wb_dat[BYPASS_BIT]) && o_wb_ack)
    else $error("bypass write not applied");
  a_lf_word_msb: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_write && reg_hit(wb_idx, IDX_LOOP_FILTER_LOW)
    |=> o_loop_filter_word[REG_W-1:0] == $past(i_wb_dat[REG_W-1:0])
        && $stable(o_loop_filter_word[REG_W]))
    else $error("loop filter low byte write wrong");
  a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_access && !i_wb_we && reg_hit(wb_idx, IDX_FB_PHASE_PD)
    |=> o_wb_ack && o_wb_dat[DAT_W-1:FB_PD_BIT+1] == '0)
    else $error("reserved bits read nonzero");
  a_ack_one_cycle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

  // Bus answer timing and read data, one register at a time
  a_ack_after_take: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_access |=> o_wb_ack)
    else $error("taken request not acknowledged");
  a_ack_only_taken: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !wb_access |=> !o_wb_ack)
    else $error("ack without a taken request");
  a_rd_data_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !wb_read |=> $stable(o_wb_dat))
    else $error("read data changed without a read");
  a_rd_filter_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_read && reg_hit(wb_idx, IDX_LOOP_FILTER_LOW)
    |=> o_wb_dat == DAT_W'($past(loop_filter_low)))
    else $error("filter low byte read wrong");
  a_rd_bypass_bit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_read && reg_hit(wb_idx, IDX_ZERO_BYPASS)
    |=> o_wb_dat == (DAT_W'($past(zero_bypass)) << BYPASS_BIT))
    else $error("bypass register read wrong");
  a_rd_prediv_code: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_read && reg_hit(wb_idx, IDX_REF_PREDIV)
    |=> o_wb_dat == DAT_W'($past(ref_prediv)))
    else $error("pre-divider code read wrong");
  a_rd_fb_ratio: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_read && reg_hit(wb_idx, IDX_FB_RATIO)
    |=> o_wb_dat == DAT_W'($past(fb_ratio)))
    else $error("feedback ratio read wrong");
  a_rd_phase_pd: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_read && reg_hit(wb_idx, IDX_FB_PHASE_PD)
    |=> o_wb_dat[FB_PHASE_W-1:0] == $past(fb_phase) && o_wb_dat[FB_PD_BIT] == $past(fb_pd))
    else $error("phase and power-down read wrong");
  a_rd_status_bits: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_read && reg_hit(wb_idx, IDX_STATUS)
    |=> o_wb_dat[0] == !$past(fb_pd) && o_wb_dat[1] == ($past(ref_prediv) <= REF_MIN_CODE)
        && o_wb_dat[DAT_W-1:2] == '0)
    else $error("status read wrong");
  a_rd_unmapped_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_read && (wb_idx < IDX_LOOP_FILTER_LOW || wb_idx > IDX_STATUS)
    |=> o_wb_dat == DAT_ZERO)
    else $error("unmapped read nonzero");

  // Writes land at the taking edge and nowhere else
  a_prediv_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_write && reg_hit(wb_idx, IDX_REF_PREDIV)
    |=> ref_prediv == $past(i_wb_dat[REF_DIV_W-1:0]))
    else $error("pre-divider write not applied");
  a_ratio_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_write && reg_hit(wb_idx, IDX_FB_RATIO)
    |=> fb_ratio == $past(i_wb_dat[FB_DIV_W-1:0]))
    else $error("feedback ratio write not applied");
  a_phase_pd_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_write && reg_hit(wb_idx, IDX_FB_PHASE_PD)
    |=> fb_phase == $past(i_wb_dat[FB_PHASE_W-1:0])
        && o_fb_powered_down == $past(i_wb_dat[FB_PD_BIT]))
    else $error("phase or power-down write not applied");
  a_lf_word_bypass: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_write && reg_hit(wb_idx, IDX_ZERO_BYPASS)
    |=> o_loop_filter_word[REG_W] == $past(i_wb_dat[BYPASS_BIT]))
    else $error("loop filter word top bit wrong");
  a_no_stray_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !wb_write |=> $stable(loop_filter_low) && $stable(zero_bypass) && $stable(ref_prediv)
        && $stable(fb_ratio) && $stable(fb_phase) && $stable(fb_pd))
    else $error("register changed without a write");

  // Counters move only on input events, except that power-down clears the feedback counter
  a_ref_idle_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_ref_edge |=> $stable(ref_if.cnt) && !o_ref_div_pulse)
    else $error("pre-divider moved without an edge");
  a_ref_step_up: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ref_edge && ref_if.cnt < ref_if.top
    |=> ref_if.cnt == $past(ref_if.cnt) + REF_DIV_W'(1) && !o_ref_div_pulse)
    else $error("pre-divider step wrong");
  a_fb_idle_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_vco_edge && !i_sync && !fb_pd |=> $stable(fb_if.cnt) && !o_fb_div_pulse)
    else $error("feedback divider moved without an edge");
  a_fb_step_up: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_vco_edge && !i_sync && !fb_pd && fb_if.cnt < fb_if.top
    |=> fb_if.cnt == $past(fb_if.cnt) + FB_CNT_W'(1) && !o_fb_div_pulse)
    else $error("feedback divider step wrong");
  a_fb_pulse_cause: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_fb_div_pulse |-> $past(i_vco_edge) && !$past(fb_pd) && !$past(i_sync))
    else $error("feedback pulse without a counted edge");

  // Reset clears every output
  a_reset_outputs: assert property (@(posedge i_clk_sys)
    i_rst |=> !o_wb_ack && o_wb_dat == DAT_ZERO && !o_ref_div_pulse && !o_fb_div_pulse
        && !o_fb_powered_down && !o_loop_zero_bypass && o_loop_filter_word == '0)
    else $error("outputs not cleared by reset");

  c_sync_load: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    i_sync && !fb_pd && fb_phase != '0);
  c_fb_pulse: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    o_fb_div_pulse && fb_ratio != '0);
  c_ref_pulse: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    o_ref_div_pulse && ref_prediv > REF_MIN_CODE);
  c_bypass_set: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_loop_zero_bypass));
  c_status_read: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    wb_read && reg_hit(wb_idx, IDX_STATUS));
endmodule

// file: dv/pdc_ctrl_test.sv
// Self-checking bench for the second-stage loop divider control block
`timescale 1ns/1ps
module pdc_ctrl_test;
  import pdc_pkg::*;
  logic                 i_clk_sys, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
  logic [ADR_W-1:0]     i_wb_adr;
  logic [DAT_W-1:0]     i_wb_dat, o_wb_dat, rd, rr;
  logic [SEL_W-1:0]     i_wb_sel;
  logic                 i_ref_edge, i_vco_edge, i_sync, en_ref, en_vco;
  logic                 o_ref_div_pulse, o_fb_div_pulse, o_fb_powered_down, o_loop_zero_bypass;
  logic [LF_WORD_W-1:0] o_loop_filter_word;
  logic [31:0]          seed;
  logic [IDX_W-1:0]     idx;
  logic [7:0]           model [6];
  logic [7:0]           mask [6] = '{8'hff, 8'h01, 8'h1f, 8'hff, 8'h7f, 8'h00};
  int                   n_fail, total_checks, re, fe, r_last, f_last, r_iv, f_iv, r_n, f_n, t;

  pdc_ctrl dut (.i_clk_sys, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat,
    .i_wb_sel, .o_wb_ack, .o_wb_dat, .i_ref_edge, .i_vco_edge, .i_sync, .o_ref_div_pulse,
    .o_fb_div_pulse, .o_fb_powered_down, .o_loop_zero_bypass, .o_loop_filter_word);

  always #2 i_clk_sys = ~i_clk_sys;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Random input edges keep the dividers honest about counting events, not cycles
  always @(posedge i_clk_sys) begin
    rr = xs();
    i_ref_edge <= en_ref & rr[3];
    i_vco_edge <= en_vco & rr[7];
  end

  // Interval model: edges counted between output pulses; sync restarts the count
  always @(posedge i_clk_sys) begin
    if (o_ref_div_pulse) begin
      r_iv = re - r_last;
      r_last = re;
      r_n++;
    end
    if (o_fb_div_pulse) begin
      f_iv = fe - f_last;
      f_last = fe;
      f_n++;
    end
    if (i_ref_edge) re++;
    if (i_sync) f_last = fe;
    else if (i_vco_edge) fe++;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [IDX_W-1:0] ix, input logic [7:0] d);
    logic [31:0] r;
    r = xs();
    @(posedge i_clk_sys);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= {ix, r[1:0]};
    i_wb_dat <= {r[31:8], d};
    i_wb_sel <= {r[7:5], 1'b1};
    do @(posedge i_clk_sys); while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask

  task automatic waitp(input bit fb, input int k);
    int t0;
    t0 = fb ? f_n : r_n;
    for (int i = 0; i < 8000 && (fb ? f_n : r_n) < t0 + k; i++) @(posedge i_clk_sys);
    if ((fb ? f_n : r_n) < t0 + k) chk("pulse count", t0 + k, fb ? f_n : r_n);
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge i_clk_sys);
    n_fail++;
    report_and_stop();
  end

  initial begin
    {i_clk_sys, i_wb_cyc, i_wb_stb, i_wb_we, i_sync, en_ref, en_vco} = '0;
    {i_wb_adr, i_wb_dat, i_wb_sel} = '0;
    {n_fail, total_checks, re, fe, r_last, f_last, r_n, f_n} = '0;
    i_rst = 1'b1;
    seed = 32'hc47e46df;
    model = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    // Reset values, then random writes; last index is unmapped
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 6; i++) begin
        idx = (i == 5) ? 10'h20b : IDX_LOOP_FILTER_LOW + 10'(i);
        if (k > 0) begin
          wb(1'b1, idx, 8'(xs()));
          model[i] = i_wb_dat[7:0] & mask[i];
        end
        wb(1'b0, idx, 8'h00);
        chk("register read", {24'h0, model[i]}, rd);
      end
    end
    wb(1'b1, IDX_ZERO_BYPASS, 8'hff);
    model[1] = 8'h01;
    wb(1'b0, IDX_ZERO_BYPASS, 8'h00);
    chk("bypass level", 32'(model[1][0]), 32'(o_loop_zero_bypass));
    chk("filter word", {23'h0, model[1][0], model[0]}, 32'(o_loop_filter_word));
    chk("power-down level", 32'(model[4][6]), 32'(o_fb_powered_down));
    wb(1'b0, IDX_STATUS, 8'h00);
    chk("status", {30'h0, model[2][4:0] <= 5'h01, !model[4][6]}, rd);
    en_ref <= 1'b1;
    foreach (mask[c]) begin
      t = (c == 5) ? 31 : c;
      wb(1'b1, IDX_REF_PREDIV, 8'(t));
      waitp(1'b0, 3);
      chk("ref interval", (t < 2) ? 1 : t, r_iv);
    end
    wb(1'b1, IDX_FB_PHASE_PD, 8'h00);
    en_vco <= 1'b1;
    foreach (mask[c]) begin
      t = (c > 3) ? 255 : 2 * c + c / 3;
      wb(1'b1, IDX_FB_RATIO, 8'(t));
      waitp(1'b1, 3);
      chk("feedback interval", 2 * (t + 1), f_iv);
    end
    wb(1'b1, IDX_FB_RATIO, 8'h03);
    foreach (mask[c]) begin
      t = (c == 5) ? 63 : c + 3;
      wb(1'b1, IDX_FB_PHASE_PD, 8'(t));
      en_vco <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      i_sync <= 1'b1;
      @(posedge i_clk_sys);
      i_sync <= 1'b0;
      en_vco <= 1'b1;
      waitp(1'b1, 1);
      chk("sync interval", (t >= 7) ? 1 : 8 - t, f_iv);
    end
    // Powered down: no pulses even across a sync
    wb(1'b1, IDX_FB_PHASE_PD, 8'h40);
    repeat (2) @(posedge i_clk_sys);
    chk("power-down level", 1, 32'(o_fb_powered_down));
    t = f_n;
    repeat (300) @(posedge i_clk_sys);
    i_sync <= 1'b1;
    @(posedge i_clk_sys);
    i_sync <= 1'b0;
    repeat (300) @(posedge i_clk_sys);
    chk("pulses while down", t, f_n);
    wb(1'b1, IDX_FB_PHASE_PD, 8'h80);
    waitp(1'b1, 3);
    chk("resumed interval", 8, f_iv);
    report_and_stop();
  end
endmodule
